// [vdmc_pkg.sv]
// Shared constants, types and address helpers for the memory controller
package vdmc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ  = 50;
  localparam int FULL_NS  = 250;
  localparam int PAGE_NS  = 125;
  localparam int PRE_NS   = 80;
  localparam int FULL_CYC = (FULL_NS * CLK_MHZ + 999) / 1000;
  localparam int PAGE_CYC = (PAGE_NS * CLK_MHZ + 999) / 1000;
  localparam int PRE_CYC  = (PRE_NS * CLK_MHZ + 999) / 1000;
  localparam int RAS_CYC  = FULL_CYC - PAGE_CYC;
  localparam logic [1:0] DIV_LAST = 2'h2;
  localparam logic [3:0] FULL_TOP = 4'(FULL_CYC - 1);
  localparam logic [3:0] CAS_TOP  = 4'(PAGE_CYC - 1);
  localparam logic [3:0] RAS_TOP  = 4'(RAS_CYC - 1);
  localparam logic [3:0] PRE_TOP  = 4'(PRE_CYC - 1);
  localparam logic [3:0] CAS_END  = 4'h2;
  localparam logic [1:0] BEAT_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Address fields of the processor bus
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 26;
  localparam int DRAM_AW  = 12;
  localparam int LPN_W    = 13;
  localparam int PPN_W    = 7;
  localparam int CAM_DEPTH = 128;
  localparam int CAM_SEL_BIT = 22;
  localparam logic [2:0] TOP_IO  = 3'h6;
  localparam logic [2:0] TOP_ROM = 3'h7;
  localparam logic [1:0] TOP_PHYS = 2'h2;
  localparam logic [2:0] SEL_CTRL   = 3'h0;
  localparam logic [2:0] SEL_VIDEO  = 3'h1;
  localparam logic [2:0] SEL_CURSOR = 3'h2;
  localparam logic [2:0] SEL_SOUND  = 3'h3;
  localparam logic [1:0] PS_RESET = 2'h0;
  localparam logic [1:0] PROT_RW  = 2'h0;
  localparam logic [1:0] PROT_RO  = 2'h1;

  typedef enum logic [2:0] {S_IDLE, S_PRE, S_RAS, S_CAS, S_SLOW, S_DONE} state_t;

  // Physical column bits above the in-page offset, per page size
  function automatic logic [9:0] colOf(input logic [6:0] ppn, input logic [2:0] off,
                                       input logic [1:0] ps);
    case (ps)
      2'h0:    colOf = {3'h0, ppn};
      2'h1:    colOf = {2'h0, ppn, off[0]};
      2'h2:    colOf = {1'h0, ppn, off[1:0]};
      default: colOf = {ppn, off};
    endcase
  endfunction

endpackage

// [cam_table.sv]
// Associative logical-to-physical page table, one entry per physical page
`timescale 1ns/10ps
module cam_table (
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  input  wire logic                        wrEn,
  input  wire logic [6:0]                  wrIdx,
  input  wire logic [vdmc_pkg::LPN_W-1:0]  wrLpn,
  input  wire logic [1:0]                  wrProt,
  input  wire logic                        lookEn,
  input  wire logic [vdmc_pkg::LPN_W-1:0]  lookLpn,
  output logic                             hit_q,
  output logic [6:0]                       ppn_q,
  output logic [1:0]                       prot_q
);

  logic [vdmc_pkg::LPN_W-1:0] lpnMem [vdmc_pkg::CAM_DEPTH];
  logic [1:0]                 protMem [vdmc_pkg::CAM_DEPTH];
  logic [vdmc_pkg::CAM_DEPTH-1:0] valid_q;
  logic                       hitD;
  logic [6:0]                 ppnD;

  // Match search; the lowest matching entry wins if software doubles up
  always_comb begin
    hitD = 1'b0;
    ppnD = 7'h00;
    for (int i = vdmc_pkg::CAM_DEPTH - 1; i >= 0; i--) begin
      if (valid_q[i] && lpnMem[i] == lookLpn) begin
        hitD = 1'b1;
        ppnD = 7'(i);
      end
    end
  end

  // Entry storage; only valid bits need a reset value
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      lpnMem[wrIdx]  <= wrLpn;
      protMem[wrIdx] <= wrProt;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      valid_q <= '0;
    end else if (wrEn) begin
      valid_q[wrIdx] <= 1'b1;
    end
  end

  // Lookup result held until the next lookup
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hit_q  <= 1'b0;
      ppn_q  <= 7'h00;
      prot_q <= 2'h0;
    end else if (lookEn) begin
      hit_q  <= hitD;
      ppn_q  <= ppnD;
      prot_q <= protMem[ppnD];
    end
  end

endmodule

// [virtual_dram_memory_controller.sv]
// Memory controller: clocks, decode, page translation, DRAM timing and DMA
`timescale 1ns/10ps
// How it works
// - Divide master clock by three for processor.
// - All system timing from the one clock.
// - Register writes carry data on address bits.
// - ROM select at nonsequential start, drop otherwise.
// - Separate selects for DRAM, ROM, I/O.
// - Drive DRAM array up to 4 Mbytes.
// - Sequential references use page-mode cycles.
// - 128-entry associative logical page lookup.
// - Page size 4K to 32K selectable.
// - One descriptor per each of 128 physical pages.
// - Row untranslated, column carries physical page.
// - Three protection levels checked per access.
// - Internal video, cursor, sound DMA address generators.
// - Arbitrate memory; controller sources every address.
// - DMA burst: one full then three page cycles.
// - Stall processor; device latches on ack fall.
module virtual_dram_memory_controller (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic [25:0]          cpuAddr,
  input  wire logic                 cpuMreqN,
  input  wire logic                 cpuSeq,
  input  wire logic                 cpuWrite,
  input  wire logic                 cpuPriv,
  input  wire logic [2:0]           dmaReq,
  output logic                      procClk_q,
  output logic                      refClk_q,
  output logic                      cpuStall_q,
  output logic                      cpuAbort_q,
  output logic                      rasN_q,
  output logic                      casN_q,
  output logic                      dramWeN_q,
  output logic [11:0]               dramAddr_q,
  output logic                      romSelN_q,
  output logic                      ioSelN_q,
  output logic [2:0]                dmaAck_q
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [32:0] sync1_q;
  logic [32:0] sync2_q;

  // Two stages before anything reads a pin
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // Request pin idles high, so reset shows no request
      sync1_q <= {6'h00, 1'b1, 26'h0000000};
      sync2_q <= {6'h00, 1'b1, 26'h0000000};
    end else begin
      sync1_q <= {dmaReq, cpuPriv, cpuWrite, cpuSeq, cpuMreqN, cpuAddr};
      sync2_q <= sync1_q;
    end
  end

  wire [25:0] la      = sync2_q[25:0];
  wire        mreq    = ~sync2_q[26];
  wire        seq     = sync2_q[27];
  wire        wr      = sync2_q[28];
  wire        priv    = sync2_q[29];
  wire [2:0]  dmaReqS = sync2_q[32:30];

  // ----------------------------------------------------------------
  // Clock divider
  // ----------------------------------------------------------------
  logic [1:0] div_q;
  wire        cpuEn = (div_q == vdmc_pkg::DIV_LAST);

  // One enable pulse in three master cycles
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 2'h0;
    end else begin
      div_q <= cpuEn ? 2'h0 : div_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire isLog  = ~la[25];
  wire isPhys = (la[25:24] == vdmc_pkg::TOP_PHYS);
  wire isIo   = (la[25:23] == vdmc_pkg::TOP_IO);
  wire isRom  = (la[25:23] == vdmc_pkg::TOP_ROM) && !wr;
  wire isRegW = (la[25:23] == vdmc_pkg::TOP_ROM) && wr;
  // User mode may touch only logical memory and ROM
  wire userBad = !priv && (isPhys || isIo || isRegW);

  // ----------------------------------------------------------------
  // Register-write buffer (two entries)
  // ----------------------------------------------------------------
  logic [22:0] buf_q [2];
  logic [1:0]  bufCnt_q;
  logic        camLook;
  wire         bufInReady = (bufCnt_q != 2'h2);
  wire         bufOutValid = (bufCnt_q != 2'h0);
  // The table cannot take a write in a lookup cycle
  wire         bufOutReady = !camLook;
  wire         bufPop = bufOutValid && bufOutReady;
  logic        bufPush;
  wire [22:0]  head = buf_q[0];
  wire         headCam = head[vdmc_pkg::CAM_SEL_BIT];
  wire [2:0]   headSel = head[21:19];
  wire [19:0]  headBase = {head[18:2], 3'h0};

  // Shift-out buffer; push lands behind whatever remains
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bufCnt_q <= 2'h0;
      buf_q[0] <= 23'h000000;
      buf_q[1] <= 23'h000000;
    end else begin
      if (bufPop) begin
        buf_q[0] <= buf_q[1];
      end
      if (bufPush) begin
        buf_q[(bufCnt_q == 2'h2 || (bufCnt_q == 2'h1 && !bufPop)) ? 1 : 0] <= la[22:0];
      end
      bufCnt_q <= bufCnt_q + {1'b0, bufPush} - {1'b0, bufPop};
    end
  end

  // ----------------------------------------------------------------
  // Control register and DMA address generators
  // ----------------------------------------------------------------
  logic [1:0]  ps_q;
  logic [19:0] ptr_q [3];
  logic [1:0]  chan_q;
  logic        dmaFinish;
  wire         ctrlWr = bufPop && !headCam && headSel == vdmc_pkg::SEL_CTRL;

  // Page size and DMA start words decoded from the buffered address
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ps_q <= vdmc_pkg::PS_RESET;
      for (int i = 0; i < 3; i++) begin
        ptr_q[i] <= 20'h00000;
      end
    end else begin
      if (ctrlWr) begin
        ps_q <= head[3:2];
      end
      if (dmaFinish) begin
        ptr_q[chan_q] <= ptr_q[chan_q] + 20'h00004;
      end
      for (int i = 0; i < 3; i++) begin
        if (bufPop && !headCam && headSel == 3'(i + 1)) begin
          ptr_q[i] <= headBase;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Page table
  // ----------------------------------------------------------------
  logic       camHit;
  logic [6:0] camPpn;
  logic [1:0] camProt;
  wire [12:0] lookLpn = la[24:12] >> ps_q;

  cam_table camTable (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .wrEn    (bufPop && headCam),
    .wrIdx   (head[6:0]),
    .wrLpn   (head[21:9]),
    .wrProt  (head[8:7]),
    .lookEn  (camLook),
    .lookLpn (lookLpn),
    .hit_q   (camHit),
    .ppn_q   (camPpn),
    .prot_q  (camProt)
  );

  // ----------------------------------------------------------------
  // Arbitration and request capture
  // ----------------------------------------------------------------
  vdmc_pkg::state_t state_q;
  vdmc_pkg::state_t stateD;
  logic [3:0]  cnt_q;
  logic [3:0]  cntD;
  logic [1:0]  beat_q;
  logic        served_q;
  logic        relDue_q;
  logic        kindDma_q;
  logic        kindLog_q;
  logic        romK_q;
  logic        wr_q;
  logic        priv_q;
  logic [7:0]  tgtRow_q;
  logic [9:0]  physHi_q;
  logic [7:0]  openRow_q;

  // Video first: a starved display is the most visible failure
  wire [1:0]  grantCh = dmaReqS[0] ? 2'h0 : (dmaReqS[1] ? 2'h1 : 2'h2);
  wire [19:0] gPtr = ptr_q[grantCh];
  wire        atBoundary = (state_q == vdmc_pkg::S_IDLE) && cpuEn;
  wire        takeDma = atBoundary && (dmaReqS != 3'h0);
  wire        takeCpu = atBoundary && !takeDma && mreq && !served_q
                        && !(isRegW && !userBad && !bufInReady);
  wire        takeDram = takeCpu && !userBad && (isLog || isPhys);
  wire [7:0]  rowNext = takeDma ? gPtr[9:2] : la[11:4];
  wire        rowOpen = !rasN_q;
  wire        pageHit = rowOpen && seq && rowNext == openRow_q;

  assign bufPush = takeCpu && isRegW && !userBad;
  assign camLook = takeDram && isLog;

  // Access check once the lookup result has landed
  wire protOk = priv_q || camProt == vdmc_pkg::PROT_RW
                || (camProt == vdmc_pkg::PROT_RO && !wr_q);
  wire accessOk = !kindLog_q || (camHit && protOk);
  wire casFirst = (state_q == vdmc_pkg::S_CAS) && cnt_q == vdmc_pkg::CAS_TOP;
  wire lateAbort = casFirst && !accessOk;
  wire earlyAbort = takeCpu && userBad;
  // Old request still in the synchronisers: hold the clock one slot
  wire holdOff = served_q && relDue_q;
  wire cntZero = (cnt_q == 4'h0);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state and counter
  always_comb begin
    stateD = state_q;
    cntD = cntZero ? 4'h0 : cnt_q - 4'h1;
    dmaFinish = 1'b0;
    case (state_q)
      vdmc_pkg::S_IDLE: begin
        if (takeDma || takeDram) begin
          if (!takeDma && pageHit) begin
            stateD = vdmc_pkg::S_CAS;
            cntD = vdmc_pkg::CAS_TOP;
          end else if (rowOpen) begin
            stateD = vdmc_pkg::S_PRE;
            cntD = vdmc_pkg::PRE_TOP;
          end else begin
            stateD = vdmc_pkg::S_RAS;
            cntD = vdmc_pkg::RAS_TOP;
          end
        end else if (takeCpu && !userBad && !isRegW) begin
          stateD = vdmc_pkg::S_SLOW;
          cntD = vdmc_pkg::FULL_TOP;
        end else if (takeCpu) begin
          stateD = vdmc_pkg::S_DONE;
        end
      end
      vdmc_pkg::S_PRE: begin
        if (cntZero) begin
          stateD = vdmc_pkg::S_RAS;
          cntD = vdmc_pkg::RAS_TOP;
        end
      end
      vdmc_pkg::S_RAS: begin
        if (cntZero) begin
          stateD = vdmc_pkg::S_CAS;
          cntD = vdmc_pkg::CAS_TOP;
        end
      end
      vdmc_pkg::S_CAS: begin
        if (lateAbort) begin
          stateD = vdmc_pkg::S_DONE;
        end else if (cntZero && kindDma_q && beat_q != vdmc_pkg::BEAT_LAST) begin
          cntD = vdmc_pkg::CAS_TOP;
        end else if (cntZero) begin
          stateD = kindDma_q ? vdmc_pkg::S_IDLE : vdmc_pkg::S_DONE;
          dmaFinish = kindDma_q;
        end
      end
      vdmc_pkg::S_SLOW: begin
        if (cntZero) begin
          stateD = vdmc_pkg::S_DONE;
        end
      end
      vdmc_pkg::S_DONE: begin
        stateD = vdmc_pkg::S_IDLE;
      end
      default: begin
        stateD = vdmc_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= vdmc_pkg::S_IDLE;
      cnt_q <= 4'h0;
    end else begin
      state_q <= stateD;
      cnt_q <= cntD;
    end
  end

  // Request attributes held for the whole access
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      kindDma_q <= 1'b0;
      kindLog_q <= 1'b0;
      romK_q <= 1'b0;
      wr_q <= 1'b0;
      priv_q <= 1'b0;
      chan_q <= 2'h0;
      tgtRow_q <= 8'h00;
      physHi_q <= 10'h000;
      beat_q <= 2'h0;
      served_q <= 1'b0;
      relDue_q <= 1'b0;
    end else begin
      if (takeDma || takeCpu) begin
        kindDma_q <= takeDma;
        kindLog_q <= !takeDma && isLog;
        romK_q <= isRom;
        wr_q <= wr;
        priv_q <= priv;
        chan_q <= grantCh;
        tgtRow_q <= rowNext;
        physHi_q <= takeDma ? gPtr[19:10] : la[21:12];
        beat_q <= 2'h0;
      end else if (state_q == vdmc_pkg::S_CAS && cntZero) begin
        beat_q <= beat_q + 2'h1;
      end
      // Synced pins lag two cycles, so the finished access stays served
      // through the boundary after its clock pulse, or it would run twice
      if (state_q == vdmc_pkg::S_DONE) begin
        served_q <= 1'b1;
      end else if (cpuEn && relDue_q) begin
        served_q <= 1'b0;
      end
      if (state_q == vdmc_pkg::S_DONE || cpuEn) begin
        relDue_q <= 1'b0;
      end else if (procClk_q && served_q) begin
        relDue_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // DRAM, select and clock outputs
  // ----------------------------------------------------------------
  wire        casOn = (state_q == vdmc_pkg::S_CAS) && cnt_q < vdmc_pkg::CAS_TOP
                      && cnt_q >= vdmc_pkg::CAS_END;
  wire [9:0]  colHi = kindLog_q ? vdmc_pkg::colOf(camPpn, la[14:12], ps_q) : physHi_q;
  wire [11:0] colAddr = {colHi, kindDma_q ? beat_q : la[3:2]};
  wire [11:0] rowAddr = {4'h0, takeDma || takeDram ? rowNext : tgtRow_q};
  wire        closeRow = (stateD == vdmc_pkg::S_PRE) || lateAbort || earlyAbort;

  // Address pins carry only controller-made addresses
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rasN_q <= 1'b1;
      casN_q <= 1'b1;
      dramWeN_q <= 1'b1;
      dramAddr_q <= 12'h000;
      openRow_q <= 8'h00;
    end else begin
      dramAddr_q <= (state_q == vdmc_pkg::S_CAS) ? colAddr : rowAddr;
      casN_q <= !casOn;
      dramWeN_q <= !(casOn && wr_q && !kindDma_q);
      if (closeRow) begin
        rasN_q <= 1'b1;
      end else if (stateD == vdmc_pkg::S_RAS) begin
        rasN_q <= 1'b0;
        openRow_q <= tgtRow_q;
        if (state_q == vdmc_pkg::S_IDLE) begin
          openRow_q <= rowNext;
        end
      end
    end
  end

  // Selects, acknowledges, abort and clocks
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      romSelN_q <= 1'b1;
      ioSelN_q <= 1'b1;
      dmaAck_q <= 3'h0;
      cpuAbort_q <= 1'b0;
      cpuStall_q <= 1'b0;
      procClk_q <= 1'b0;
      refClk_q <= 1'b0;
    end else begin
      // Early ROM select buys slow ROM a head start
      romSelN_q <= !((takeCpu && !seq) || (state_q == vdmc_pkg::S_SLOW && romK_q));
      ioSelN_q <= !(state_q == vdmc_pkg::S_SLOW && !romK_q);
      dmaAck_q <= (casOn && kindDma_q) ? 3'(1 << chan_q) : 3'h0;
      cpuAbort_q <= lateAbort || earlyAbort;
      cpuStall_q <= (stateD != vdmc_pkg::S_IDLE);
      procClk_q <= cpuEn && stateD == vdmc_pkg::S_IDLE && !holdOff;
      refClk_q <= cpuEn;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_refDiv;
    @(posedge mclk) disable iff (!arst_n) $rose(refClk_q) |-> ##3 $rose(refClk_q);
  endproperty
  a_refDiv: assert property (p_refDiv) else $error("reference clock not divided by three");

  property p_holdClk;
    @(posedge mclk) disable iff (!arst_n) cpuStall_q |-> !procClk_q;
  endproperty
  a_holdClk: assert property (p_holdClk) else $error("processor clocked while stalled");

  property p_romEarly;
    @(posedge mclk) disable iff (!arst_n) (takeCpu && !seq && !isRom) |=> !romSelN_q ##1 romSelN_q;
  endproperty
  a_romEarly: assert property (p_romEarly) else $error("ROM select not raised then withdrawn");

  property p_selExcl;
    @(posedge mclk) disable iff (!arst_n) !(!romSelN_q && !ioSelN_q);
  endproperty
  a_selExcl: assert property (p_selExcl) else $error("ROM and I/O selects overlap");

  sequence s_beat;
    (dmaAck_q != 3'h0) ##7 (dmaAck_q != 3'h0);
  endsequence
  property p_dmaBurst;
    @(posedge mclk) disable iff (!arst_n)
      (takeDma && rasN_q) |-> ##9 s_beat ##7 s_beat ##7 (dmaAck_q == 3'h0);
  endproperty
  a_dmaBurst: assert property (p_dmaBurst) else $error("DMA burst is not four beats");

  property p_dmaPage;
    @(posedge mclk) disable iff (!arst_n) (takeDma && rasN_q) |=> !rasN_q [*8];
  endproperty
  a_dmaPage: assert property (p_dmaPage) else $error("row strobe dropped inside a burst");

  property p_abortNoCas;
    @(posedge mclk) disable iff (!arst_n) cpuAbort_q |-> (casN_q && rasN_q) ##1 casN_q;
  endproperty
  a_abortNoCas: assert property (p_abortNoCas) else $error("memory strobed on abort");

  property p_missAbort;
    @(posedge mclk) disable iff (!arst_n)
      (casFirst && kindLog_q && (!camHit || !protOk)) |=> cpuAbort_q;
  endproperty
  a_missAbort: assert property (p_missAbort) else $error("bad translation not aborted");

  property p_rowRaw;
    @(posedge mclk) disable iff (!arst_n) $fell(rasN_q) |-> dramAddr_q == {4'h0, openRow_q};
  endproperty
  a_rowRaw: assert property (p_rowRaw) else $error("row address not the untranslated row");

  property p_grant;
    @(posedge mclk) disable iff (!arst_n)
      (atBoundary && dmaReqS != 3'h0) |=> (kindDma_q && cpuStall_q);
  endproperty
  a_grant: assert property (p_grant) else $error("pending DMA not granted at boundary");

endmodule

// [dma_device.sv]
// Behavioural DMA requester that latches its data when the acknowledge falls
`timescale 1ns/10ps
module dma_device (
  input  wire logic mclk,
  input  wire logic arstN,
  input  wire logic go,
  input  wire logic ack,
  output logic      req,
  output int        falls
);
  // ----------------------------------------------------------------
  // Request and latch
  // ----------------------------------------------------------------
  logic ackQ;
  // Drop the request at the first ack fall so a single burst is served
  always_ff @(posedge mclk or negedge arstN) begin
    if (!arstN) begin
      req <= 1'b0;
      ackQ <= 1'b0;
      falls <= 0;
    end else begin
      ackQ <= ack;
      if (go) req <= 1'b1;
      else if (ackQ && !ack) req <= 1'b0;
      if (ackQ && !ack) falls <= falls + 1;  // Data latched here
    end
  end
endmodule

// [tb_virtual_dram_memory_controller.sv]
// Self-checking bench for the memory controller
`timescale 1ns/10ps
module tb_virtual_dram_memory_controller;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic        mclk, arstN, mreqN, seq, wr, priv, go, vReq;
  logic [25:0] addr, a;
  logic [2:0]  dmaAck;
  logic        procClk, refClk, stall, abortP, rasN, casN, weN, romN, ioN;
  logic [11:0] dAddr, sRow;
  logic [12:0] lpn, pg;
  logic [6:0]  idx;
  logic        sAbort, romAny, romMid, ioMid;
  logic [1:0]  protM [logic [12:0]];
  int          errors, checked, n, casLo, weLo;

  virtual_dram_memory_controller dut_u (.mclk(mclk), .arst_n(arstN), .cpuAddr(addr),
    .cpuMreqN(mreqN), .cpuSeq(seq), .cpuWrite(wr), .cpuPriv(priv), .dmaReq({2'h0, vReq}),
    .procClk_q(procClk), .refClk_q(refClk), .cpuStall_q(stall), .cpuAbort_q(abortP),
    .rasN_q(rasN), .casN_q(casN), .dramWeN_q(weN), .dramAddr_q(dAddr),
    .romSelN_q(romN), .ioSelN_q(ioN), .dmaAck_q(dmaAck));
  dma_device dev_u (.mclk(mclk), .arstN(arstN), .go(go), .ack(dmaAck[0]), .req(vReq),
    .falls());

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Reference abort decision: miss, protection or user reach into I/O
  function automatic logic expAbort(input logic [25:0] x, input logic w, input logic p);
    if (!x[25]) begin
      if (!protM.exists(x[24:12])) return 1'b1;
      if (p) return 1'b0;
      return (protM[x[24:12]] == 2'h1) ? w : (protM[x[24:12]] != 2'h0);
    end
    return (x[25:23] == 3'h6) && !p;
  endfunction

  // Request held until the processor clock pulses after the stall
  task automatic acc(input logic [25:0] x, input logic w, input logic p);
    logic prevRas, got, seen;
    int k;
    prevRas = 1'b1;
    got = 1'b0;
    seen = 1'b0;
    k = 0;
    casLo = 0;
    weLo = 0;
    {sAbort, romAny, romMid, ioMid} = 4'h3;
    @(posedge mclk);
    addr <= x;
    wr <= w;
    priv <= p;
    mreqN <= 1'b0;
    for (n = 0; n < 80; n++) begin
      @(posedge mclk);
      if (abortP === 1'b1) sAbort = 1'b1;
      if (casN === 1'b0) casLo++;
      if (weN === 1'b0) weLo++;
      if (romN === 1'b0) romAny = 1'b1;
      // A row left open by the last access is not this access's row
      if (rasN === 1'b0 && prevRas === 1'b1 && stall === 1'b1 && !got) begin
        sRow = dAddr;
        got = 1'b1;
      end
      prevRas = rasN;
      if (seen) k++;
      if (stall === 1'b1) seen = 1'b1;
      if (k == 8) begin
        romMid = romN;
        ioMid = ioN;
      end
      if (seen && procClk === 1'b1) break;
    end
    mreqN <= 1'b1;
    chk(32'(n < 80), 32'h1);  // Processor released after the stall
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and scenarios
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    #(20 * 20000);
    errors++;
    end_of_test();
  end

  initial begin
    {arstN, seq, wr, priv, go} = 5'h0;
    mreqN = 1'b1;
    addr = 26'h0;
    errors = 0;
    checked = 0;
    repeat (5) @(posedge mclk);
    arstN <= 1'b1;
    void'($urandom(32'h5128d222));
    repeat (6) @(posedge mclk);
    n = 0;
    k_loop : for (int i = 0; i < 30; i++) begin
      @(posedge mclk);
      n += int'(refClk) + 16 * int'(procClk);
    end
    chk(32'(n), 32'd170);  // Ten of each in 30 cycles
    acc({3'h7, 23'h0}, 1'b0, 1'b1);
    chk({romMid, ioMid, sAbort}, 32'h2);  // ROM read
    acc({3'h6, 23'h40}, 1'b0, 1'b1);
    chk({romAny, romMid, ioMid, sAbort}, 32'hc);  // I/O read
    acc({3'h6, 23'h40}, 1'b0, 1'b0);
    chk(32'(sAbort), 32'h1);  // User reach into I/O
    lpn = 13'($urandom) | 13'h1;
    idx = 7'($urandom);
    acc({3'h7, 1'b1, lpn, 2'h1, idx}, 1'b1, 1'b1);  // Table entry on address
    protM[lpn] = 2'h1;
    for (int k = 0; k < 5; k++) begin
      pg = (k == 4) ? (lpn ^ 13'h1000) : lpn;
      a = {1'b0, pg, 8'($urandom), 4'h0};
      acc(a, k[0], k[1]);
      chk(32'(sAbort), 32'(expAbort(a, k[0], k[1])));
      chk(32'(sRow), {24'h0, a[11:4]});
      // One column cycle with CAS low four clocks, write enable low with it on writes
      chk(32'(casLo + 16 * weLo), expAbort(a, k[0], k[1]) ? 32'h0 : (k[0] ? 32'd68 : 32'd4));
      chk({romAny, romMid}, 32'h3);  // Select withdrawn for DRAM
    end
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (90) @(posedge mclk);
    chk(32'(dev_u.falls), 32'd4);  // One burst of four beats
    end_of_test();
  end
endmodule
